/* logic/tcs_pkg.sv */
// Constants shared by the transmit clock and slot select block
package tcs_pkg;

  // ---------------------------------------------------------------
  // Bus layout
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_HF_CTL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_BIT_CTL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SLOT_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FRAME_CFG = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_SLOT_STAT = 8'h10;

  // ---------------------------------------------------------------
  // High-frequency clock control fields
  // ---------------------------------------------------------------
  localparam int HF_SRC_BIT = 15;
  localparam int HF_INV_BIT = 14;
  localparam int HF_DIV_W = 12;
  localparam logic [DATA_W-1:0] HF_CTL_WMASK = 32'h0000_cfff;
  localparam logic [DATA_W-1:0] HF_CTL_RESET = 32'h0000_8000;

  // ---------------------------------------------------------------
  // Bit clock control fields
  // ---------------------------------------------------------------
  localparam int BIT_SRC_BIT = 5;
  localparam int BIT_DIV_W = 5;
  localparam logic [DATA_W-1:0] BIT_CTL_WMASK = 32'h0000_003f;
  localparam logic [DATA_W-1:0] BIT_CTL_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Slot mask and frame
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] SLOT_MASK_RESET = 32'h0000_0000;
  localparam int SLOT_W = 9;
  localparam int SLOT_IDX_W = 5;
  localparam logic [SLOT_W-1:0] MAX_SLOTS = 9'h180;
  localparam logic [SLOT_W-1:0] FRAME_SLOTS_RESET = 9'h002;
  localparam int NSER = 4;

endpackage

/* logic/tcs_clk_div.sv */
// Tick counting clock divider with near half duty output
`timescale 1ns/10ps
`default_nettype none
module tcs_clk_div #(
  parameter int W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic [W-1:0] div,
  output logic clk_out
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic out_r;
  wire logic wrap = (cnt_r >= div);
  wire logic [W-1:0] half = {1'b0, div[W-1:1]};

  // Reload on terminal count
  assign cnt_nxt = !tick ? cnt_r : (wrap ? '0 : cnt_r + 1'b1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= (cnt_nxt <= half);
    end
  end

  assign clk_out = out_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  count_bound_a: assert property (tick |=> cnt_r <= $past(div))
    else $error("divider count passed its terminal value");
  count_reload_a: assert property (tick && cnt_r == div |=> cnt_r == '0)
    else $error("divider did not reload at terminal count");

endmodule
`default_nettype wire

/* logic/tcs_top.sv */
// Transmit high-frequency clock, bit clock and slot enable control
//
// Notes on behaviour
// - Source bit 15: 0 takes the hf clock pin, 1 the internal divider.
// - Polarity bit 14 inverts the hf clock before the bit clock divider.
// - Internal bit clock dividing by one passes the hf clock straight out.
// - Auxiliary clock divides by the 12-bit field plus one.
// - Hf control bits 31-16 and 13-12 read zero and ignore writes.
// - Slot counter covers frames of up to 384 slots.
// - Mask bit n governs every slot whose number modulo 32 is n.
// - Mask bit 0 makes the slot inactive; no serializer shifts.
// - Mask bit 1 lets configured serializers shift during the slot.
// - Bit clock divider divides the hf clock by 5-bit field plus one.
// - Bit source bit picks divider output when internal, else the pin.
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module tcs_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tcs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [tcs_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [tcs_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tcs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [tcs_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic auxiliary_source_clock,
  input wire logic tx_high_freq_clock_in,
  output logic tx_high_freq_clock_out,
  output logic tx_high_freq_clock_oe,
  input wire logic tx_bit_clock_in,
  output logic tx_bit_clock_out,
  output logic tx_bit_clock_oe,
  input wire logic frame_start,
  input wire logic slot_advance,
  input wire logic [tcs_pkg::NSER-1:0] serializer_configuration,
  output logic [tcs_pkg::SLOT_W-1:0] tx_slot_num,
  output logic tx_slot_active,
  output logic [tcs_pkg::NSER-1:0] serializer_shift_en
);
  import tcs_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] hf_ctl_r;
  logic [DATA_W-1:0] bit_ctl_r;
  logic [DATA_W-1:0] tx_slot_enable_mask_r;
  logic [SLOT_W-1:0] frame_slots_r;
  logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [DATA_W-1:0] w_data_r, rdata_r;
  logic [STRB_W-1:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic rd_hf_r;

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic do_wr = aw_full_r && w_full_r && !bvalid_r;
  wire logic wr_hf = do_wr && (aw_addr_r == OFS_HF_CTL);
  wire logic wr_bit = do_wr && (aw_addr_r == OFS_BIT_CTL);
  wire logic wr_mask = do_wr && (aw_addr_r == OFS_SLOT_MASK);
  wire logic wr_frame = do_wr && (aw_addr_r == OFS_FRAME_CFG);
  wire logic wr_hit = wr_hf || wr_bit || wr_mask || wr_frame ||
                      (aw_addr_r == OFS_SLOT_STAT);
  logic [DATA_W-1:0] strb_mask;

  genvar gi;
  generate
    for (gi = 0; gi < STRB_W; gi++) begin : g_strb
      assign strb_mask[gi*8 +: 8] = {8{w_strb_r[gi]}};
    end
  endgenerate

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] nw,
                                              input logic [DATA_W-1:0] m,
                                              input logic [DATA_W-1:0] keep);
    merge = ((old & ~m) | (nw & m)) & keep;
  endfunction

  wire logic [DATA_W-1:0] hf_ctl_nxt = merge(hf_ctl_r, w_data_r, strb_mask, HF_CTL_WMASK);
  wire logic [DATA_W-1:0] bit_ctl_nxt = merge(bit_ctl_r, w_data_r, strb_mask, BIT_CTL_WMASK);
  wire logic [DATA_W-1:0] mask_nxt = merge(tx_slot_enable_mask_r, w_data_r, strb_mask, '1);
  wire logic [DATA_W-1:0] frame_raw = merge({{(DATA_W-SLOT_W){1'b0}}, frame_slots_r},
                                            w_data_r, strb_mask, '1);
  wire logic frame_big = (frame_raw > {{(DATA_W-SLOT_W){1'b0}}, MAX_SLOTS});
  wire logic [SLOT_W-1:0] frame_nxt = frame_big ? MAX_SLOTS : frame_raw[SLOT_W-1:0];

  assign s_axi_awready = !aw_full_r && !bvalid_r;
  assign s_axi_wready = !w_full_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else begin
      if (aw_take) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hf_ctl_r <= HF_CTL_RESET;
      bit_ctl_r <= BIT_CTL_RESET;
      tx_slot_enable_mask_r <= SLOT_MASK_RESET;
      frame_slots_r <= FRAME_SLOTS_RESET;
    end else begin
      if (wr_hf) hf_ctl_r <= hf_ctl_nxt;
      if (wr_bit) bit_ctl_r <= bit_ctl_nxt;
      if (wr_mask) tx_slot_enable_mask_r <= mask_nxt;
      if (wr_frame) frame_slots_r <= frame_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic [DATA_W-1:0] slot_stat = {{(DATA_W-SLOT_W){1'b0}}, tx_slot_num};
  wire logic [DATA_W-1:0] frame_word = {{(DATA_W-SLOT_W){1'b0}}, frame_slots_r};
  wire logic rd_hit = (s_axi_araddr == OFS_HF_CTL) || (s_axi_araddr == OFS_BIT_CTL) ||
                      (s_axi_araddr == OFS_SLOT_MASK) || (s_axi_araddr == OFS_FRAME_CFG) ||
                      (s_axi_araddr == OFS_SLOT_STAT);
  logic [DATA_W-1:0] rd_mux;

  assign rd_mux = (s_axi_araddr == OFS_HF_CTL) ? (hf_ctl_r & HF_CTL_WMASK) :
                  (s_axi_araddr == OFS_BIT_CTL) ? bit_ctl_r :
                  (s_axi_araddr == OFS_SLOT_MASK) ? tx_slot_enable_mask_r :
                  (s_axi_araddr == OFS_FRAME_CFG) ? frame_word :
                  (s_axi_araddr == OFS_SLOT_STAT) ? slot_stat : '0;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
      rd_hf_r <= 1'b0;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rd_hf_r <= (s_axi_araddr == OFS_HF_CTL);
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic aux_s1_r, aux_s2_r, aux_d_r;
  logic hf_ext_s1_r, hf_ext_s2_r, bit_ext_s1_r, bit_ext_s2_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aux_s1_r, aux_s2_r, aux_d_r} <= '0;
      {hf_ext_s1_r, hf_ext_s2_r, bit_ext_s1_r, bit_ext_s2_r} <= '0;
    end else begin
      aux_s1_r <= auxiliary_source_clock;
      aux_s2_r <= aux_s1_r;
      aux_d_r <= aux_s2_r;
      hf_ext_s1_r <= tx_high_freq_clock_in;
      hf_ext_s2_r <= hf_ext_s1_r;
      bit_ext_s1_r <= tx_bit_clock_in;
      bit_ext_s2_r <= bit_ext_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // High-frequency clock
  // ---------------------------------------------------------------
  wire logic [HF_DIV_W-1:0] hf_div = hf_ctl_r[HF_DIV_W-1:0];
  wire logic hf_src_int = hf_ctl_r[HF_SRC_BIT];
  wire logic aux_tick = aux_s2_r && !aux_d_r;
  logic hf_div_out, hf_out_r, hf_inv_d_r;

  tcs_clk_div #(.W(HF_DIV_W)) u_hf_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(aux_tick),
    .div(hf_div),
    .clk_out(hf_div_out)
  );

  wire logic hf_int = (hf_div == '0) ? aux_s2_r : hf_div_out;
  wire logic hf_level = hf_src_int ? hf_int : hf_ext_s2_r;
  wire logic hf_inv = hf_out_r ^ hf_ctl_r[HF_INV_BIT];
  wire logic bit_tick = hf_inv && !hf_inv_d_r;

  // ---------------------------------------------------------------
  // Bit clock
  // ---------------------------------------------------------------
  wire logic [BIT_DIV_W-1:0] bit_div = bit_ctl_r[BIT_DIV_W-1:0];
  wire logic bit_src_int = bit_ctl_r[BIT_SRC_BIT];
  logic bit_div_out, bit_out_r;

  tcs_clk_div #(.W(BIT_DIV_W)) u_bit_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(bit_tick),
    .div(bit_div),
    .clk_out(bit_div_out)
  );

  wire logic bit_int = (bit_div == '0) ? hf_out_r : bit_div_out;
  wire logic bit_level = bit_src_int ? bit_int : bit_ext_s2_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hf_out_r <= 1'b0;
      hf_inv_d_r <= 1'b0;
      bit_out_r <= 1'b0;
    end else begin
      hf_out_r <= hf_level;
      hf_inv_d_r <= hf_inv;
      bit_out_r <= bit_level;
    end
  end

  assign tx_high_freq_clock_out = hf_out_r;
  assign tx_high_freq_clock_oe = hf_src_int;
  assign tx_bit_clock_out = bit_out_r;
  assign tx_bit_clock_oe = bit_src_int;

  // ---------------------------------------------------------------
  // Slot counter and enable mask
  // ---------------------------------------------------------------
  logic [SLOT_W-1:0] slot_r;
  wire logic slot_last = ({1'b0, slot_r} + 1'b1 >= {1'b0, frame_slots_r});
  wire logic [SLOT_W-1:0] slot_nxt = frame_start ? '0 :
                                     !slot_advance ? slot_r :
                                     slot_last ? '0 : slot_r + 1'b1;
  wire logic [SLOT_IDX_W-1:0] slot_idx = slot_r[SLOT_IDX_W-1:0];
  wire logic slot_on = tx_slot_enable_mask_r[slot_idx];

  always_ff @(posedge aclk) begin
    if (!aresetn) slot_r <= '0;
    else slot_r <= slot_nxt;
  end

  assign tx_slot_num = slot_r;
  assign tx_slot_active = slot_on;
  assign serializer_shift_en = {NSER{slot_on}} & serializer_configuration;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence ext_hf_held;
    !hf_src_int [*2];
  endsequence

  hf_ext_source_a: assert property (ext_hf_held |-> hf_out_r == $past(hf_ext_s2_r))
    else $error("hf clock not following its pin");
  hf_int_source_a: assert property (hf_src_int && hf_div == '0 && $stable(hf_ctl_r)
                                    |=> hf_out_r == $past(aux_s2_r))
    else $error("hf clock divide-by-one not bypassed");
  bit_tick_edge_a: assert property (bit_tick |-> hf_out_r != $past(hf_out_r) ||
                                    $changed(hf_ctl_r[HF_INV_BIT]))
    else $error("bit divider ticked without an hf edge");
  bit_pass_through_a: assert property (bit_src_int && bit_div == '0 && $stable(bit_ctl_r)
                                       |=> bit_out_r == $past(hf_out_r))
    else $error("bit clock not passing hf clock");
  bit_ext_source_a: assert property (!bit_src_int ##1 !bit_src_int
                                     |-> bit_out_r == $past(bit_ext_s2_r))
    else $error("bit clock not following its pin");
  hf_reserved_read_a: assert property (rvalid_r && rd_hf_r |-> (rdata_r & ~HF_CTL_WMASK) == '0)
    else $error("hf control reserved bits read nonzero");
  slot_range_a: assert property (slot_r < MAX_SLOTS)
    else $error("slot counter beyond frame limit");
  slot_wrap_a: assert property (slot_advance && !frame_start && slot_last |=> slot_r == '0)
    else $error("slot counter did not wrap");
  slot_modulo_a: assert property (tx_slot_active == tx_slot_enable_mask_r[slot_r % 32])
    else $error("slot mask not applied modulo 32");
  slot_idle_a: assert property (!tx_slot_active |-> serializer_shift_en == '0)
    else $error("serializer shifts in an inactive slot");
  slot_busy_a: assert property (tx_slot_active |-> serializer_shift_en == serializer_configuration)
    else $error("serializer held back in an active slot");

endmodule
`default_nettype wire

/* tb/tcs_codec_model.sv */
// Far-side codec model that drives the transmit clock pins
`timescale 1ns/10ps
`default_nettype none
module tcs_codec_model (
  input wire logic aclk,
  input wire logic run,
  output logic hf_pin,
  output logic bit_pin
);
  int hc = 0;
  int bc = 0;

  initial begin
    hf_pin = 1'b0;
    bit_pin = 1'b0;
  end

  // Pin clocks stand still low while run is low
  always @(posedge aclk) begin
    if (!run) begin
      hc <= 0;
      bc <= 0;
      hf_pin <= 1'b0;
      bit_pin <= 1'b0;
    end else begin
      hc <= (hc == 2) ? 0 : hc + 1;
      bc <= (bc == 4) ? 0 : bc + 1;
      if (hc == 2) hf_pin <= ~hf_pin;
      if (bc == 4) bit_pin <= ~bit_pin;
    end
  end
endmodule
`default_nettype wire

/* tb/tcs_top_tb.sv */
// Self-checking bench for the transmit clock and slot select block
`timescale 1ns/10ps
`default_nettype none
module tcs_top_tb;
  import tcs_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, aux, hf_pin, hf_out, hf_oe;
  logic bit_pin, bit_out, bit_oe, fs, adv, act, run, hf_at;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, d, mask;
  logic [STRB_W-1:0] wstrb;
  logic [1:0] bresp, rresp, r, aux_cnt;
  logic [NSER-1:0] cfg, shen;
  logic [SLOT_W-1:0] slot;
  int err_total, compares, p, seed;
  int hdivs[$] = '{0, 1, 2, 5};
  int bdivs[$] = '{1, 31};

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk) aux_cnt <= aux_cnt + 2'h1;
  assign aux = aux_cnt[1];

  tcs_top dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .auxiliary_source_clock(aux), .tx_high_freq_clock_in(hf_pin),
    .tx_high_freq_clock_out(hf_out), .tx_high_freq_clock_oe(hf_oe),
    .tx_bit_clock_in(bit_pin), .tx_bit_clock_out(bit_out), .tx_bit_clock_oe(bit_oe),
    .frame_start(fs), .slot_advance(adv), .serializer_configuration(cfg),
    .tx_slot_num(slot), .tx_slot_active(act), .serializer_shift_en(shen)
  );

  tcs_codec_model codec (.aclk(aclk), .run(run), .hf_pin(hf_pin), .bit_pin(bit_pin));

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic results();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 200) begin
      err_total++;
      $display("Error wait expected answer seen none");
      results();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) ad = 1'b1;
      if (wready === 1'b1) wd = 1'b1;
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end while (!(ad && wd) && n < 200);
    tmo(n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid !== 1'b1 && n < 200);
    tmo(n);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 200);
    tmo(n);
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 200);
    tmo(n);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // Cycles between the second and third rising edge of a clock output
  task automatic per(input logic sb, output int pp);
    logic pv, cu;
    int st, t0, n;
    pv = 1'b1;
    st = 0;
    t0 = 0;
    pp = 0;
    for (n = 0; n < 3000 && st < 3; n++) begin
      @(negedge aclk);
      cu = sb ? bit_out : hf_out;
      if (cu === 1'b1 && pv === 1'b0) begin
        st++;
        hf_at = hf_out;
        if (st == 2) t0 = n;
        pp = n - t0;
      end
      pv = cu;
    end
    if (st < 3) tmo(200);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h2c2532ff;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, fs, adv, run} = '0;
    {awaddr, araddr, wdata, cfg, aux_cnt} = '0;
    wstrb = 4'hf;
    err_total = 0;
    compares = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_HF_CTL, d, r);
    chk("hf_ctl_reset", d, 32'h0000_8000);
    rd(8'h20, d, r);
    chk("rresp_unmapped", r, RESP_SLVERR);
    wr(8'h20, 32'h1, r);
    chk("bresp_unmapped", r, RESP_SLVERR);
    wr(OFS_HF_CTL, 32'hffff_ffff, r);
    rd(OFS_HF_CTL, d, r);
    chk("hf_ctl_reserved", d, 32'h0000_cfff);
    mask = $random(seed);
    wr(OFS_SLOT_MASK, mask, r);
    rd(OFS_SLOT_MASK, d, r);
    chk("slot_mask", d, mask);
    wr(OFS_BIT_CTL, 32'h20, r);
    foreach (hdivs[i]) begin
      wr(OFS_HF_CTL, 32'h8000 | hdivs[i], r);
      chk("hf_oe", hf_oe, 1);
      per(1'b0, p);
      chk("hf_period", p, 4 * (hdivs[i] + 1));
      per(1'b1, p);
      chk("bit_div1", p, 4 * (hdivs[i] + 1));
    end
    wr(OFS_HF_CTL, 32'h8001, r);
    foreach (bdivs[i]) begin
      wr(OFS_BIT_CTL, 32'h20 | bdivs[i], r);
      chk("bit_oe", bit_oe, 1);
      per(1'b1, p);
      chk("bit_period", p, 8 * (bdivs[i] + 1));
      chk("bit_phase", hf_at, 1);
    end
    wr(OFS_HF_CTL, 32'hc001, r);
    per(1'b1, p);
    chk("bit_period_inv", p, 256);
    chk("bit_phase_inv", hf_at, 0);
    wr(OFS_HF_CTL, 32'h0, r);
    run <= 1'b1;
    chk("hf_oe_ext", hf_oe, 0);
    per(1'b0, p);
    chk("hf_period_ext", p, 6);
    wr(OFS_BIT_CTL, 32'h0, r);
    chk("bit_oe_ext", bit_oe, 0);
    per(1'b1, p);
    chk("bit_period_ext", p, 10);
    wr(OFS_FRAME_CFG, 32'h1ff, r);
    run <= 1'b0;
    rd(OFS_FRAME_CFG, d, r);
    chk("frame_clamp", d, 32'h180);
    fs <= 1'b1;
    cfg <= NSER'($random(seed));
    @(posedge aclk);
    fs <= 1'b0;
    for (int s = 0; s <= 384; s++) begin
      @(negedge aclk);
      chk("slot", slot, s % 384);
      chk("active", act, mask[s % 32]);
      chk("shift", shen, cfg & {NSER{mask[s % 32]}});
      @(posedge aclk);
      adv <= 1'b1;
      cfg <= NSER'($random(seed));
      @(posedge aclk);
      adv <= 1'b0;
    end
    @(posedge aclk);
    adv <= 1'b1;
    repeat (5) @(posedge aclk);
    fs <= 1'b1;
    @(posedge aclk);
    {adv, fs} <= 2'h0;
    @(negedge aclk);
    chk("slot_restart", slot, 0);
    results();
  end
endmodule
`default_nettype wire
